// >>> core/ahbsp_dev.sv
`timescale 1ns/1ps
// Contract
// RL1: Master keeps device clock running always.
// RL2: Select, rw, selects, data, ack carry accesses.
// RL3: Vector strobes replace select, ignore selects.
// RL4: Master asserts at most one strobe.
// RL5: Capture selects and rw on select.
// RL6: Master never aborts cycles to device.
// RL7: Ignore select until three periods after ack.
// RL8: Select latch transparent while ready.
// RL9: Drive data buffers soon after select.
// RL10: Sample select, ack next edge.
// RL11: Read data held while select asserted.
// RL12: Four-cycle access, vector one more.
// RL13: Master holds inputs until ack seen.
// RL14: Select rise drives ack high, releases.
// RL15: Capture write data on select.
// RL16: Vector strobes pick port or timer vector.
// RL17: Vector: sync, drive, then ack.
// RL18: Vector negation drives ack high, releases.
// RL19: Master holds strobe until ack low.
module ahbsp_dev #(
  parameter int unsigned DATA_W = ahbsp_pkg::AHBSP_DATA_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  ahbsp_if.dev bus,
  // Register file side
  output logic [4:0] reg_addr_o,
  output logic [7:0] wr_data_o,
  output logic wr_stb_o,
  output logic rd_stb_o,
  input wire logic [7:0] rd_data_i,
  input wire logic [7:0] port_vector_i,
  input wire logic [7:0] timer_vector_i,
  output logic port_iack_o,
  output logic timer_iack_o
);
  import ahbsp_pkg::*;
  // Data path is byte wide only
  if (DATA_W != 8) begin : g_width_check
    $error("data width must be 8");
  end
  // Saturating step of the recovery counter
  function automatic logic [2:0] count_down(input logic [2:0] cnt);
    logic [2:0] nxt;
    nxt = cnt;
    if (cnt != 3'h0) begin
      nxt = cnt - 3'h1;
    end
    return nxt;
  endfunction
  // One decode for both vector strobes
  function automatic logic vec_active(input logic port_n, input logic timer_n);
    return !port_n || !timer_n;
  endfunction
  // Register read decode, shared by data latch and strobe
  function automatic logic reg_read(input logic is_vec, input logic rw);
    return !is_vec && rw;
  endfunction
  // Register write decode
  function automatic logic reg_write(input logic is_vec, input logic rw);
    return !is_vec && !rw;
  endfunction
  // One-hot codes; a stray code falls back to idle
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SYNC = 6'h02,
    ST_VEC = 6'h04,
    ST_ACK = 6'h08,
    ST_RLS = 6'h10,
    ST_RECOV = 6'h20
  } ahbsp_st_t;
  // Whole state in one register, copied and updated each cycle
  typedef struct packed {
    ahbsp_st_t st;
    logic [4:0] sel;
    logic rw;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic drive;
    logic ack;
    logic ack_oe;
    logic [2:0] cnt;
    logic is_vec;
    logic timer;
    logic wr_stb;
    logic rd_stb;
    logic port_iack;
    logic timer_iack;
  } ahbsp_state_t;
  // Ack held negated in reset so the line never reads asserted
  localparam ahbsp_state_t STATE_RST = '{
    st: ST_IDLE,
    sel: AHBSP_SEL_RST,
    rw: 1'b1,
    wdat: AHBSP_DATA_RST,
    rdat: AHBSP_DATA_RST,
    drive: 1'b0,
    ack: 1'b1,
    ack_oe: 1'b0,
    cnt: 3'h0,
    is_vec: 1'b0,
    timer: 1'b0,
    wr_stb: 1'b0,
    rd_stb: 1'b0,
    port_iack: 1'b0,
    timer_iack: 1'b0
  };
  ahbsp_state_t s_q, s_d;
  logic any_strobe;
  logic drive_phase;
  // Any of the three strobes marks a live cycle
  assign any_strobe = !bus.select_n || vec_active(bus.port_vector_ack_n, bus.timer_vector_ack_n);
  // Buffers only between recognition and strobe negation
  assign drive_phase = s_q.st == ST_RLS || s_q.st == ST_ACK;
  // Next state; the four strobe fields clear each cycle, every other field holds unless a state says otherwise
  always_comb begin
    s_d = s_q;
    s_d.wr_stb = 1'b0;
    s_d.rd_stb = 1'b0;
    s_d.port_iack = 1'b0;
    s_d.timer_iack = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        // Transparent latch while ready; inputs held stable by master [RL8] [RL13]
        s_d.sel = bus.reg_select;
        s_d.rw = bus.rd_wr;
        s_d.wdat = bus.data_m;
        s_d.ack_oe = 1'b0;
        if (!bus.select_n) begin
          // Capture on recognition of select [RL5] [RL15] [RL10]
          s_d.is_vec = 1'b0;
          s_d.st = ST_ACK;
          s_d.drive = bus.rd_wr; // [RL9]
        end else if (vec_active(bus.port_vector_ack_n, bus.timer_vector_ack_n)) begin
          // Selects ignored, vector register chosen [RL3] [RL16]
          s_d.is_vec = 1'b1;
          s_d.timer = !bus.timer_vector_ack_n;
          s_d.st = ST_VEC;
        end
      end
      ST_VEC: begin
        // One clock after recognition the vector goes out [RL17] [RL12]
        s_d.rdat = s_q.timer ? timer_vector_i : port_vector_i;
        s_d.drive = 1'b1;
        s_d.st = ST_ACK;
      end
      ST_ACK: begin
        // Ack low with read data latched together [RL10] [RL11] [RL17]
        if (reg_read(s_q.is_vec, s_q.rw)) begin
          s_d.rdat = rd_data_i;
        end
        s_d.ack = 1'b0;
        s_d.ack_oe = 1'b1;
        s_d.wr_stb = reg_write(s_q.is_vec, s_q.rw);
        s_d.rd_stb = reg_read(s_q.is_vec, s_q.rw);
        // Recovery counts from the ack edge, so a slow negation costs nothing extra [RL7]
        s_d.cnt = AHBSP_RECOVER_CYC - 3'h1;
        s_d.st = ST_RLS;
      end
      ST_RLS: begin
        s_d.cnt = count_down(s_q.cnt);
        if (!any_strobe) begin
          // Negated strobe: release data, pull ack high [RL14] [RL18]
          s_d.ack = 1'b1;
          s_d.drive = 1'b0;
          s_d.port_iack = s_q.is_vec && !s_q.timer;
          s_d.timer_iack = s_q.is_vec && s_q.timer;
          s_d.st = ST_RECOV;
        end
      end
      ST_RECOV: begin
        // Pull-up phase ends, then three-state; re-select ignored [RL7] [RL14]
        s_d.ack_oe = 1'b0;
        s_d.cnt = count_down(s_q.cnt);
        // Idle one edge early so a strobe lands on the third period [RL12]
        if (s_q.cnt <= 3'h1) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end
  // Synchronous reset; bus pins are taken as already in this clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end
  // Buffers driven only in the selected phase [RL2] [RL9]
  assign bus.data_s = s_q.rdat;
  assign bus.data_s_oe = s_q.drive && drive_phase && any_strobe;
  assign bus.transfer_ack_n = s_q.ack;
  assign bus.transfer_ack_oe = s_q.ack_oe;
  // Register file side
  assign reg_addr_o = s_q.sel;
  assign wr_data_o = s_q.wdat;
  assign wr_stb_o = s_q.wr_stb;
  assign rd_stb_o = s_q.rd_stb;
  assign port_iack_o = s_q.port_iack;
  assign timer_iack_o = s_q.timer_iack;
endmodule

// >>> inc/ahbsp_pkg.sv
package ahbsp_pkg;
  localparam int unsigned AHBSP_DATA_W = 8;
  localparam int unsigned AHBSP_SEL_W = 5;
  // Recovery: select recognised no earlier than three periods after ack edge
  localparam logic [2:0] AHBSP_RECOVER_CYC = 3'h3;
  // Wait between vector drive and acknowledge
  localparam logic [2:0] AHBSP_VEC_SETUP_CYC = 3'h1;
  // Reset value of the captured register select
  localparam logic [4:0] AHBSP_SEL_RST = 5'h00;
  localparam logic [7:0] AHBSP_DATA_RST = 8'h00;
endpackage

// >>> inc/ahbsp_if.sv
`timescale 1ns/1ps
interface ahbsp_if;
  logic select_n;
  logic rd_wr;
  logic [4:0] reg_select;
  logic port_vector_ack_n;
  logic timer_vector_ack_n;
  logic [7:0] data_m;
  logic data_m_oe;
  logic [7:0] data_s;
  logic data_s_oe;
  logic transfer_ack_n;
  logic transfer_ack_oe;
  modport dev (
    input select_n, rd_wr, reg_select, port_vector_ack_n, timer_vector_ack_n, data_m, data_m_oe,
    output data_s, data_s_oe, transfer_ack_n, transfer_ack_oe
  );
  modport mst (
    output select_n, rd_wr, reg_select, port_vector_ack_n, timer_vector_ack_n, data_m, data_m_oe,
    input data_s, data_s_oe, transfer_ack_n, transfer_ack_oe
  );
endinterface

// >>> core/ahbsp_mst.sv
`timescale 1ns/1ps
module ahbsp_mst (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  ahbsp_if.mst bus,
  // User request
  input wire logic req_i,
  input wire logic [1:0] kind_i,
  input wire logic rd_wr_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic ready_o,
  output logic done_o,
  output logic [7:0] rdata_o
);
  import ahbsp_pkg::*;
  typedef enum logic [2:0] {
    MS_IDLE = 3'h1,
    MS_WAIT = 3'h2,
    MS_END = 3'h4
  } ahbsp_mst_st_t;
  typedef struct packed {
    ahbsp_mst_st_t st;
    logic [1:0] kind;
    logic rw;
    logic [4:0] addr;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic done;
  } ahbsp_mst_state_t;
  ahbsp_mst_state_t m_q, m_d;
  always_comb begin
    m_d = m_q;
    m_d.done = 1'b0;
    unique case (m_q.st)
      MS_IDLE: begin
        // Device clock assumed free-running [RL1]
        if (req_i) begin
          m_d.kind = kind_i;
          m_d.rw = rd_wr_i;
          m_d.addr = addr_i;
          m_d.wdat = wdata_i;
          m_d.st = MS_WAIT;
        end
      end
      MS_WAIT: begin
        // Never abort; hold until ack low [RL6] [RL19]
        if (bus.transfer_ack_oe && !bus.transfer_ack_n) begin
          m_d.rdat = bus.data_s;
          m_d.st = MS_END;
        end
      end
      MS_END: begin
        m_d.done = 1'b1;
        m_d.st = MS_IDLE;
      end
      default: begin
        m_d.st = MS_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_q <= '{st: MS_IDLE, kind: 2'h0, rw: 1'b1, addr: AHBSP_SEL_RST, wdat: AHBSP_DATA_RST,
               rdat: AHBSP_DATA_RST, done: 1'b0};
    end else begin
      m_q <= m_d;
    end
  end
  // One strobe at a time by kind [RL4] [RL2]
  assign bus.select_n = !(m_q.st == MS_WAIT && m_q.kind == 2'h0);
  assign bus.port_vector_ack_n = !(m_q.st == MS_WAIT && m_q.kind == 2'h1);
  assign bus.timer_vector_ack_n = !(m_q.st == MS_WAIT && m_q.kind[1]);
  // Inputs stable until ack [RL13]
  assign bus.rd_wr = m_q.rw;
  assign bus.reg_select = m_q.addr;
  assign bus.data_m = m_q.wdat;
  assign bus.data_m_oe = m_q.st == MS_WAIT && !m_q.rw && m_q.kind == 2'h0;
  assign ready_o = m_q.st == MS_IDLE;
  assign done_o = m_q.done;
  assign rdata_o = m_q.rdat;
endmodule

// >>> sim/ahbsp_checker.sv
`timescale 1ns/1ps
module ahbsp_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic select_n,
  input wire logic rd_wr,
  input wire logic port_vector_ack_n,
  input wire logic timer_vector_ack_n,
  input wire logic data_m_oe,
  input wire logic [7:0] data_s,
  input wire logic data_s_oe,
  input wire logic transfer_ack_n,
  input wire logic transfer_ack_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic vec_n = port_vector_ack_n & timer_vector_ack_n;
  sequence s_ack_low; !transfer_ack_n && transfer_ack_oe; endsequence
  sequence s_held; !transfer_ack_n && !select_n; endsequence
  // Ranges allow for a strobe that lands inside recovery
  property p_sel_ack; $fell(select_n) && vec_n |-> ##[2:5] s_ack_low; endproperty
  a_sel_ack: assert property (p_sel_ack) else $error("select not acknowledged");
  property p_vec_ack; $fell(vec_n) && select_n |-> ##[3:6] s_ack_low; endproperty
  a_vec_ack: assert property (p_vec_ack) else $error("vector not acknowledged");
  property p_vec_drive; $fell(transfer_ack_n) && !vec_n |-> $past(data_s_oe); endproperty
  a_vec_drive: assert property (p_vec_drive) else $error("vector not driven before ack");
  property p_data_stable; s_held |=> $stable(data_s); endproperty
  a_data_stable: assert property (p_data_stable) else $error("read data moved");
  property p_rd_oe; (s_held and rd_wr) |-> data_s_oe; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read data not driven");
  property p_ack_high; $rose(select_n) && !transfer_ack_n |-> ##[0:2] (transfer_ack_n && transfer_ack_oe); endproperty
  a_ack_high: assert property (p_ack_high) else $error("ack not driven high");
  property p_release; $rose(transfer_ack_n) && $past(transfer_ack_oe) |-> transfer_ack_oe ##1 !transfer_ack_oe; endproperty
  a_release: assert property (p_release) else $error("ack not released");
  property p_one_strobe; $onehot0({!select_n, !port_vector_ack_n, !timer_vector_ack_n}); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two strobes at once");
  property p_no_fight; !(data_s_oe && data_m_oe); endproperty
  a_no_fight: assert property (p_no_fight) else $error("data bus driven twice");
endmodule

// >>> sim/async_host_bus_slave_port_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module async_host_bus_slave_port_tb;
  import ahbsp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic [1:0] kind_i = 2'h0;
  logic rd_wr_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] port_vector_i = 8'h00;
  logic [7:0] timer_vector_i = 8'h00;
  logic ready_o, done_o, wr_stb_o, rd_stb_o, port_iack_o, timer_iack_o;
  logic [7:0] rdata_o, wr_data_o, rd_data_i, seed;
  logic [4:0] reg_addr_o;
  int mismatches = 0;
  int num_checks = 0;
  logic [8:0] rd_q[$];
  logic [12:0] wr_q[$];
  logic [1:0] ia_q[$];
  logic [4:0] ra_q[$];
  // Request edge to done: strobe out, recognised, ack, ack seen, done
  localparam int SEL_CYC = 4;
  localparam int VEC_CYC = 5;
  ahbsp_if bus_if();
  // Readback tied to the latched address so a stale latch shows
  assign rd_data_i = {3'h5, reg_addr_o} ^ 8'h3C;
  ahbsp_dev i_ahbsp_dev (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if), .reg_addr_o(reg_addr_o), .wr_data_o(wr_data_o),
    .wr_stb_o(wr_stb_o), .rd_stb_o(rd_stb_o), .rd_data_i(rd_data_i), .port_vector_i(port_vector_i),
    .timer_vector_i(timer_vector_i), .port_iack_o(port_iack_o), .timer_iack_o(timer_iack_o));
  ahbsp_mst i_ahbsp_mst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if), .req_i(req_i), .kind_i(kind_i), .rd_wr_i(rd_wr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o));
  ahbsp_checker i_ahbsp_checker (.clk_i(clk_i), .rst_i(rst_i), .select_n(bus_if.select_n), .rd_wr(bus_if.rd_wr),
    .port_vector_ack_n(bus_if.port_vector_ack_n), .timer_vector_ack_n(bus_if.timer_vector_ack_n),
    .data_m_oe(bus_if.data_m_oe), .data_s(bus_if.data_s), .data_s_oe(bus_if.data_s_oe),
    .transfer_ack_n(bus_if.transfer_ack_n), .transfer_ack_oe(bus_if.transfer_ack_oe));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_sig(input bit sel, output int cycles);
    int n;
    n = 0;
    while ((sel ? done_o : ready_o) !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 40) begin
        mismatches++;
        end_sim();
      end
    end
    cycles = n;
  endtask
  task automatic op(input logic [1:0] k, input logic rw, input logic [4:0] a, input logic [7:0] w);
    int cycles;
    wait_sig(1'b0, cycles);
    req_i = 1'b1;
    kind_i = k;
    rd_wr_i = rw;
    addr_i = a;
    wdata_i = w;
    rd_q.push_back({rw | (k != 2'h0), k == 2'h0 ? ({3'h5, a} ^ 8'h3C) : k == 2'h1 ? port_vector_i : timer_vector_i});
    if (k == 2'h0 && !rw) wr_q.push_back({a, w});
    if (k != 2'h0) ia_q.push_back({k == 2'h1, k[1]});
    if (k == 2'h0 && rw) ra_q.push_back(a);
    @(posedge clk_i);
    #1;
    req_i = 1'b0;
    wait_sig(1'b1, cycles);
    `CHK(cycles, (k == 2'h0) ? SEL_CYC : VEC_CYC)
  endtask
  always @(posedge clk_i) begin
    if (done_o === 1'b1) begin
      if (rd_q[0][8] !== 1'b0) `CHK(rdata_o, rd_q[0][7:0])
      void'(rd_q.pop_front());
    end
    if (wr_stb_o === 1'b1) begin
      `CHK({reg_addr_o, wr_data_o}, wr_q[0])
      void'(wr_q.pop_front());
    end
    if ((port_iack_o | timer_iack_o) === 1'b1) begin
      `CHK({port_iack_o, timer_iack_o}, ia_q[0])
      void'(ia_q.pop_front());
    end
    if (rd_stb_o === 1'b1) begin
      `CHK(reg_addr_o, ra_q[0])
      void'(ra_q.pop_front());
    end
  end
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    seed = 8'h0A;
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      op(2'h0, seed[0], seed[7:3], lfsr(seed));
    end
    $display("test back to back accesses done");
    for (int k = 1; k < 4; k++) begin
      seed = lfsr(seed);
      port_vector_i = seed;
      timer_vector_i = ~seed;
      op(k[1:0], seed[1], seed[6:2], seed);
    end
    $display("test vector cycles done");
    repeat (4) @(posedge clk_i);
    `CHK(rd_q.size() + wr_q.size() + ia_q.size() + ra_q.size(), 0)
    end_sim();
  end
endmodule
